// ---- rtl/srq_status_pkg.sv ----
// Constants and carriers of the status and service-request bank.
// Assumes one clock; the synchronous reset also stands for power-up.
// Behaviour
// R1 - Poll byte bit 6 set marks a pending service request.
// R2 - Controller checks polled bit 6 to find the requester.
// R3 - Poll byte clears to zero after a serial poll.
// R4 - Poll byte bits: 7 reset, 5 lock, 4 button, 3 hw, 2 syntax, 1 seen, 0 ready.
// R5 - Bit 7 sets on power-up, power return and rear reset button.
// R6 - Bit 5 sets on lock; poll or lock loss clears it in poll byte.
// R7 - Bit 4 sets on a front-panel return button press.
// R8 - Bit 3 sets when the display reading fails.
// R9 - Malformed message sets bit 2; the command is discarded.
// R10 - Event bit 1 sets on resonance signal since read; mirrors resonance bit 3.
// R11 - Bit 0 sets at measurement end; masked after power-up and reset.
// R12 - Event register clears on read; bit 6 reads 0; with mask forms poll byte.
// R13 - Event lock bit clears on event register read or on loss of lock.
// R14 - Resonance bits 7-4 read 0; bit 3 latches appearance until read.
// R15 - Resonance register bit 2 gives the live signal presence at read time.
// R16 - Resonance bits 1 and 0 show above and below range at read.
// R17 - Function bit 7 is fast display, bit 3 field-scan mode.
// R18 - Function bits 6-4 hold multiplexer channel, 000 for A to 111 for H.
// R19 - Function bit 2 is 1 for positive field sense, 0 for negative.
// R20 - Function bit 1 is 0 in operator-set mode, 1 in automatic tracking.
// R21 - Function bit 0 is 1 for tesla display, 0 for megahertz.
// R22 - Converter register is two bytes of converter contents.
// R23 - Mask 1 passes event bits 0-5 into poll byte; all masked after reset.
// R24 - Set request bit drives the bus request line true.
// R25 - Status request 1-4: next talker read returns S plus hex.
// R26 - Request bit is OR of masked-in bits 0-5 and power bit.
package srq_status_pkg;
  localparam int BIT_POWER  = 7;
  localparam int BIT_RQS    = 6;
  localparam int BIT_LOCK   = 5;
  localparam int BIT_LOCAL  = 4;
  localparam int BIT_HWERR  = 3;
  localparam int BIT_SYNTAX = 2;
  localparam int BIT_SEEN   = 1;
  localparam int BIT_READY  = 0;
  localparam int MASK_W     = 6;
  localparam logic [7:0] EVENT_RESET = 8'h80;
  localparam logic [5:0] MASK_RESET  = 6'h00;
  localparam logic [3:0] RES_UNUSED  = 4'h0;
  // Status register selection codes, reply lengths and reply characters
  localparam logic [2:0] SEL_NONE      = 3'h0;
  localparam logic [2:0] SEL_EVENT     = 3'h1;
  localparam logic [2:0] SEL_RESONANCE = 3'h2;
  localparam logic [2:0] SEL_FUNCTION  = 3'h3;
  localparam logic [2:0] SEL_CONVERTER = 3'h4;
  localparam logic [2:0] NIB_BYTE      = 3'h2;
  localparam logic [2:0] NIB_WORD      = 3'h4;
  localparam logic [7:0] CHAR_STATUS   = 8'h53;
  localparam logic [7:0] CHAR_DIGIT0   = 8'h30;
  localparam logic [7:0] CHAR_LETTER   = 8'h37;
  // Synchronised pin indices
  localparam int SYNC_W    = 5;
  localparam int SY_LOCK   = 0;
  localparam int SY_BUTTON = 1;
  localparam int SY_SIGNAL = 2;
  localparam int SY_ABOVE  = 3;
  localparam int SY_BELOW  = 4;

  typedef enum logic [1:0] {TALK_IDLE, TALK_SEND} talk_state_t;

  typedef struct packed {
    logic       fast_display;
    logic [2:0] mux_channel;
    logic       search_mode;
    logic       field_positive;
    logic       auto_mode;
    logic       tesla_display;
  } instr_fn_t;

  typedef struct packed {
    logic [SYNC_W-1:0] meta;
    logic [SYNC_W-1:0] stable;
  } sync_state_t;

  typedef struct packed {
    logic [7:0] bits;
  } sticky_state_t;

  typedef struct packed {
    logic [7:0]  poll_byte;
    logic        srq_line;
    logic [5:0]  mask;
    logic [2:0]  sel;
    logic        lock_prev;
    logic        signal_prev;
    logic        button_prev;
    logic        seen2;
    talk_state_t talk;
    logic [15:0] snap;
    logic [2:0]  nib_left;
    logic [7:0]  talk_data;
    logic        talk_valid;
    logic        talk_last;
    logic        discard;
  } main_state_t;
endpackage : srq_status_pkg

// ---- rtl/pin_sync.sv ----
// Two-flop synchroniser for the panel and detector pins.
// Assumes asynchronous levels; only the second stage is read outside.
`timescale 1ns/100ps
`default_nettype none
module pin_sync (
  input  wire logic                            mclk_in,
  input  wire logic                            resetn_in,
  input  wire logic [srq_status_pkg::SYNC_W-1:0] pins_in,
  output logic      [srq_status_pkg::SYNC_W-1:0] pins_out
);
  srq_status_pkg::sync_state_t s_q;
  srq_status_pkg::sync_state_t s_d;

  always_comb begin
    s_d        = s_q;
    s_d.meta   = pins_in;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pins_out = s_q.stable;
endmodule : pin_sync
`default_nettype wire

// ---- rtl/sticky_bits.sv ----
// Byte of sticky event flags with per-bit set and clear.
// Assumes set and clear are one-cycle pulses on the same clock.
`timescale 1ns/100ps
`default_nettype none
module sticky_bits (
  input  wire logic       mclk_in,
  input  wire logic       resetn_in,
  input  wire logic [7:0] set_in,
  input  wire logic [7:0] clr_in,
  output logic      [7:0] bits_out
);
  srq_status_pkg::sticky_state_t s_q;
  srq_status_pkg::sticky_state_t s_d;

  // A set in the same cycle as a clear wins, so no event is lost
  always_comb begin
    s_d      = s_q;
    s_d.bits = (s_q.bits & ~clr_in) | set_in;
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      s_q.bits <= srq_status_pkg::EVENT_RESET; // R5
    end else begin
      s_q <= s_d;
    end
  end

  assign bits_out = s_q.bits;
endmodule : sticky_bits
`default_nettype wire

// ---- rtl/status_srq_regs.sv ----
// Service-request byte, status registers 1 to 4 and the status reply.
// Assumes an outside bus engine for messages and polls; panel pins are asynchronous.
`timescale 1ns/100ps
`default_nettype none
module status_srq_regs (
  input  wire logic                      mclk_in,
  input  wire logic                      resetn_in,
  // Asynchronous instrument pins
  input  wire logic                      lock_in,
  input  wire logic                      local_button_in,
  input  wire logic                      signal_present_in,
  input  wire logic                      above_range_in,
  input  wire logic                      below_range_in,
  // Same-domain instrument events and state
  input  wire logic                      hw_error_in,
  input  wire logic                      syntax_error_in,
  input  wire logic                      measure_done_in,
  input  wire srq_status_pkg::instr_fn_t fn_in,
  input  wire logic [15:0]               converter_in,
  // Bus engine side
  input  wire logic                      mask_wr_in,
  input  wire logic [5:0]                mask_in,
  input  wire logic                      sel_wr_in,
  input  wire logic [2:0]                sel_in,
  input  wire logic                      poll_done_in,
  input  wire logic                      talk_req_in,
  input  wire logic                      talk_ready_in,
  output logic [7:0]                     poll_byte_out,
  output logic                           srq_out,
  output logic                           status_mode_out,
  output logic [7:0]                     talk_data_out,
  output logic                           talk_valid_out,
  output logic                           talk_last_out,
  output logic                           discard_out
);

  // ----------------------------------------------------------------
  // Hex character
  // ----------------------------------------------------------------
  function automatic logic [7:0] hex_char(input logic [3:0] nib);
    hex_char = {4'h0, nib} + (nib < 4'ha ? srq_status_pkg::CHAR_DIGIT0
      : srq_status_pkg::CHAR_LETTER);
  endfunction : hex_char

  // ----------------------------------------------------------------
  // Nibble pick, most significant first
  // ----------------------------------------------------------------
  function automatic logic [3:0] pick_nib(input logic [15:0] val,
                                          input logic [2:0]  left);
    case (left)
      3'h4:    pick_nib = val[15:12];
      3'h3:    pick_nib = val[11:8];
      3'h2:    pick_nib = val[7:4];
      3'h1:    pick_nib = val[3:0];
      default: pick_nib = 4'h0;
    endcase
  endfunction : pick_nib

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [srq_status_pkg::SYNC_W-1:0] pins_raw;
  logic [srq_status_pkg::SYNC_W-1:0] pins_s;

  assign pins_raw[srq_status_pkg::SY_LOCK]   = lock_in;
  assign pins_raw[srq_status_pkg::SY_BUTTON] = local_button_in;
  assign pins_raw[srq_status_pkg::SY_SIGNAL] = signal_present_in;
  assign pins_raw[srq_status_pkg::SY_ABOVE]  = above_range_in;
  assign pins_raw[srq_status_pkg::SY_BELOW]  = below_range_in;

  pin_sync u_sync (
    .mclk_in   (mclk_in),
    .resetn_in (resetn_in),
    .pins_in   (pins_raw),
    .pins_out  (pins_s)
  );

  logic lock_s;
  logic button_s;
  logic signal_s;
  logic above_s;
  logic below_s;

  assign lock_s   = pins_s[srq_status_pkg::SY_LOCK];
  assign button_s = pins_s[srq_status_pkg::SY_BUTTON];
  assign signal_s = pins_s[srq_status_pkg::SY_SIGNAL];
  assign above_s  = pins_s[srq_status_pkg::SY_ABOVE];
  assign below_s  = pins_s[srq_status_pkg::SY_BELOW];

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  srq_status_pkg::main_state_t s_q;
  srq_status_pkg::main_state_t s_d;

  // ----------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------
  logic lock_rise;
  logic lock_fall;
  logic button_rise;
  logic signal_rise;

  assign lock_rise   = lock_s & ~s_q.lock_prev;
  assign lock_fall   = ~lock_s & s_q.lock_prev;
  assign button_rise = button_s & ~s_q.button_prev;
  assign signal_rise = signal_s & ~s_q.signal_prev;

  logic [7:0] ev_set;

  always_comb begin
    ev_set                            = 8'h00;
    ev_set[srq_status_pkg::BIT_LOCK]   = lock_rise;       // R6
    ev_set[srq_status_pkg::BIT_LOCAL]  = button_rise;     // R7
    ev_set[srq_status_pkg::BIT_HWERR]  = hw_error_in;     // R8
    ev_set[srq_status_pkg::BIT_SYNTAX] = syntax_error_in; // R9
    ev_set[srq_status_pkg::BIT_SEEN]   = signal_rise;     // R10
    ev_set[srq_status_pkg::BIT_READY]  = measure_done_in; // R11
  end

  // ----------------------------------------------------------------
  // Talker take and read side effects
  // ----------------------------------------------------------------
  logic talk_take;
  logic read_event;
  logic read_resonance;

  assign talk_take = talk_req_in && (s_q.talk == srq_status_pkg::TALK_IDLE)
                     && (s_q.sel != srq_status_pkg::SEL_NONE);
  assign read_event     = talk_take && (s_q.sel == srq_status_pkg::SEL_EVENT);
  assign read_resonance = talk_take && (s_q.sel == srq_status_pkg::SEL_RESONANCE);

  logic [7:0] lock_clr;

  always_comb begin
    lock_clr                          = 8'h00;
    lock_clr[srq_status_pkg::BIT_LOCK] = lock_fall; // R6 R13
  end

  // ----------------------------------------------------------------
  // Sticky banks
  // ----------------------------------------------------------------
  logic [7:0] event_bits;
  logic [7:0] cause_bits;
  logic [7:0] event_clr;
  logic [7:0] cause_clr;

  assign event_clr = read_event ? 8'hff : lock_clr;   // R12 R13
  assign cause_clr = poll_done_in ? 8'hff : lock_clr; // R3

  // Internal event register
  sticky_bits u_event (
    .mclk_in   (mclk_in),
    .resetn_in (resetn_in),
    .set_in    (ev_set),
    .clr_in    (event_clr),
    .bits_out  (event_bits)
  );

  // Poll-byte causes; own copy so a poll and a register read stay apart
  sticky_bits u_cause (
    .mclk_in   (mclk_in),
    .resetn_in (resetn_in),
    .set_in    (ev_set),
    .clr_in    (cause_clr),
    .bits_out  (cause_bits)
  );

  // ----------------------------------------------------------------
  // Service request byte
  // ----------------------------------------------------------------
  logic [5:0] passed;
  logic       rqs;
  logic [7:0] poll_next;

  assign passed = cause_bits[5:0] & s_q.mask;                          // R23
  assign rqs    = cause_bits[srq_status_pkg::BIT_POWER] | (|passed);   // R26

  always_comb begin
    poll_next = {cause_bits[srq_status_pkg::BIT_POWER], rqs, passed}; // R4
    if (poll_done_in) begin
      poll_next = 8'h00; // R3
    end
  end

  // ----------------------------------------------------------------
  // Status register read values
  // ----------------------------------------------------------------
  logic [7:0] reg_event;
  logic [7:0] reg_resonance;
  logic [7:0] reg_function;
  logic [15:0] read_value;
  logic [2:0]  read_nibs;

  always_comb begin
    reg_event                          = event_bits;
    reg_event[srq_status_pkg::BIT_RQS] = 1'b0; // R12
  end

  // Live bits are taken at the cycle the read is accepted
  assign reg_resonance = {srq_status_pkg::RES_UNUSED, // R14
                          s_q.seen2,                  // R14
                          signal_s,                   // R15
                          above_s,                    // R16
                          below_s};                   // R16

  assign reg_function = {fn_in.fast_display,   // R17
                         fn_in.mux_channel,    // R18
                         fn_in.search_mode,    // R17
                         fn_in.field_positive, // R19
                         fn_in.auto_mode,      // R20
                         fn_in.tesla_display}; // R21

  always_comb begin
    read_value = 16'h0000;
    read_nibs  = srq_status_pkg::NIB_BYTE;
    case (s_q.sel)
      srq_status_pkg::SEL_EVENT:     read_value = {8'h00, reg_event};
      srq_status_pkg::SEL_RESONANCE: read_value = {8'h00, reg_resonance};
      srq_status_pkg::SEL_FUNCTION:  read_value = {8'h00, reg_function};
      srq_status_pkg::SEL_CONVERTER: begin
        read_value = converter_in; // R22
        read_nibs  = srq_status_pkg::NIB_WORD;
      end
      default: read_value = 16'h0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d             = s_q;
    s_d.lock_prev   = lock_s;
    s_d.signal_prev = signal_s;
    s_d.button_prev = button_s;
    s_d.discard     = syntax_error_in; // R9
    s_d.poll_byte   = poll_next;       // R1
    s_d.srq_line    = poll_next[srq_status_pkg::BIT_RQS]; // R24

    // Signal seen latch of the resonance register; set wins over read
    if (read_resonance) begin
      s_d.seen2 = 1'b0; // R14
    end
    if (signal_rise) begin
      s_d.seen2 = 1'b1; // R10 R14
    end

    if (mask_wr_in) begin
      s_d.mask = mask_in; // R23
    end

    // Only codes 1 to 4 name a register; the parser flags anything else
    if (sel_wr_in && (sel_in >= srq_status_pkg::SEL_EVENT)
        && (sel_in <= srq_status_pkg::SEL_CONVERTER)) begin
      s_d.sel = sel_in; // R25
    end

    case (s_q.talk)
      srq_status_pkg::TALK_IDLE: begin
        if (talk_take) begin
          s_d.talk       = srq_status_pkg::TALK_SEND;
          s_d.snap       = read_value;
          s_d.nib_left   = read_nibs;
          s_d.talk_data  = srq_status_pkg::CHAR_STATUS; // R25
          s_d.talk_valid = 1'b1;
          s_d.talk_last  = 1'b0;
        end
      end
      srq_status_pkg::TALK_SEND: begin
        if (talk_ready_in) begin
          if (s_q.nib_left == 3'h0) begin
            // Selection is spent: later talker reads get the field value
            s_d.talk       = srq_status_pkg::TALK_IDLE;
            s_d.talk_valid = 1'b0;
            s_d.talk_last  = 1'b0;
            s_d.sel        = srq_status_pkg::SEL_NONE;
          end else begin
            s_d.talk_data = hex_char(pick_nib(s_q.snap, s_q.nib_left)); // R25
            s_d.nib_left  = s_q.nib_left - 3'h1;
            s_d.talk_last = (s_q.nib_left == 3'h1);
          end
        end
      end
      default: begin
        s_d.talk       = srq_status_pkg::TALK_IDLE;
        s_d.talk_valid = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      s_q             <= '0;
      s_q.mask        <= srq_status_pkg::MASK_RESET; // R11 R23
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign poll_byte_out   = s_q.poll_byte;
  assign srq_out         = s_q.srq_line;
  assign status_mode_out = (s_q.sel != srq_status_pkg::SEL_NONE);
  assign talk_data_out   = s_q.talk_data;
  assign talk_valid_out  = s_q.talk_valid;
  assign talk_last_out   = s_q.talk_last;
  assign discard_out     = s_q.discard;
endmodule : status_srq_regs
`default_nettype wire

// ---- test/status_srq_regs_properties.sv ----
// Concurrent checks on the poll byte and the status reply stream.
// Assumes one clock and the bank's synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module status_srq_checker (
  input wire logic       mclk_in,
  input wire logic       resetn_in,
  input wire logic       lock_in,
  input wire logic       syntax_error_in,
  input wire logic       poll_done_in,
  input wire logic       talk_req_in,
  input wire logic       talk_ready_in,
  input wire logic [7:0] poll_byte_out,
  input wire logic       srq_out,
  input wire logic       status_mode_out,
  input wire logic [7:0] talk_data_out,
  input wire logic       talk_valid_out,
  input wire logic       talk_last_out,
  input wire logic       discard_out
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  AST_POWER_BIT: assert property ($rose(resetn_in) |=> poll_byte_out == 8'hc0 && srq_out)
    else $error("power bit missing after reset");
  AST_RQS_SUM: assert property (poll_byte_out[6] == (poll_byte_out[7] || |poll_byte_out[5:0]))
    else $error("request bit not the sum of causes");
  AST_SRQ_LINE: assert property (srq_out == poll_byte_out[6])
    else $error("bus request line differs from request bit");
  AST_POLL_CLEAR: assert property (poll_done_in |=> poll_byte_out == 8'h00 && !srq_out)
    else $error("poll byte not cleared after poll");
  // Six low cycles cover the synchroniser and the edge detect
  AST_LOCK_LOSS: assert property (!lock_in [*6] |-> !poll_byte_out[5])
    else $error("lock bit kept after loss of lock");
  AST_DISCARD: assert property (syntax_error_in |=> discard_out)
    else $error("malformed command not discarded");
  AST_REPLY_START: assert property (talk_req_in && status_mode_out && !talk_valid_out
    |=> talk_valid_out && talk_data_out == 8'h53)
    else $error("status reply does not open with S");
  AST_CHAR_HOLD: assert property (talk_valid_out && !talk_ready_in
    |=> talk_valid_out && $stable(talk_data_out) && $stable(talk_last_out))
    else $error("reply character changed while stalled");
  AST_REPLY_END: assert property (talk_valid_out && talk_last_out && talk_ready_in
    |=> !talk_valid_out && !status_mode_out)
    else $error("reply did not end after last character");
endmodule : status_srq_checker

bind status_srq_regs status_srq_checker chk (
  .mclk_in(mclk_in), .resetn_in(resetn_in), .lock_in(lock_in),
  .syntax_error_in(syntax_error_in), .poll_done_in(poll_done_in),
  .talk_req_in(talk_req_in), .talk_ready_in(talk_ready_in),
  .poll_byte_out(poll_byte_out), .srq_out(srq_out), .status_mode_out(status_mode_out),
  .talk_data_out(talk_data_out), .talk_valid_out(talk_valid_out),
  .talk_last_out(talk_last_out), .discard_out(discard_out)
);
`default_nettype wire

// ---- test/bus_controller_model.sv ----
// Bus controller model: serial polls and talker reply collection.
// Assumes a shared clock; slow mode stalls every other slot.
`timescale 1ns/100ps
`default_nettype none
module bus_controller_model (
  input  wire logic       mclk_in,
  input  wire logic [7:0] poll_byte_in,
  input  wire logic [7:0] talk_data_in,
  input  wire logic       talk_valid_in,
  input  wire logic       talk_last_in,
  input  wire logic       slow_in,
  output logic            poll_done_out,
  output logic            talk_ready_out
);
  logic [7:0] rx [0:7];
  int         rx_n;
  logic       rx_end;
  initial begin
    poll_done_out = 1'b0;
    talk_ready_out = 1'b1;
    rx_n = 0;
    rx_end = 1'b0;
  end
  // ----------------------------------------
  // Listener side of a talker transfer
  // ----------------------------------------
  always @(posedge mclk_in) begin
    // Slow mode refuses every other slot to exercise the hold
    talk_ready_out <= slow_in ? ~talk_ready_out : 1'b1;
    if (talk_valid_in && talk_ready_out) begin
      rx[rx_n[2:0]] <= talk_data_in;
      rx_n <= rx_n + 1;
      rx_end <= talk_last_in;
    end
  end
  task automatic clear_rx();
    rx_n = 0;
    rx_end = 1'b0;
  endtask : clear_rx
  task automatic serial_poll(output logic [7:0] b, output logic rqs);
    @(posedge mclk_in);
    b = poll_byte_in;
    rqs = b[6];
    poll_done_out <= 1'b1;
    @(posedge mclk_in);
    poll_done_out <= 1'b0;
  endtask : serial_poll
endmodule : bus_controller_model
`default_nettype wire

// ---- test/status_and_service_request_regs_test.sv ----
// Self-checking bench for the status and service-request bank.
// Assumes the controller model; 20 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module status_and_service_request_regs_test;
  logic mclk_in = 1'b0, resetn_in = 1'b0, lock_in = 1'b0, local_button_in = 1'b0;
  logic signal_present_in = 1'b0, above_range_in = 1'b0, below_range_in = 1'b0;
  logic hw_error_in = 1'b0, syntax_error_in = 1'b0, measure_done_in = 1'b0;
  logic mask_wr_in = 1'b0, sel_wr_in = 1'b0, talk_req_in = 1'b0, slow = 1'b0;
  logic poll_done_in, talk_ready_in, srq_out, status_mode_out;
  logic talk_valid_out, talk_last_out, discard_out;
  logic [5:0]  mask_in = 6'h00;
  logic [2:0]  sel_in = 3'h0;
  logic [15:0] converter_in = 16'h0000;
  logic [7:0]  poll_byte_out, talk_data_out, pb;
  logic        rqs;
  srq_status_pkg::instr_fn_t fn_in = '0;
  int          fail_count = 0;
  int          n_compared = 0;
  int          cycles = 0;
  status_srq_regs uut (
    .mclk_in(mclk_in), .resetn_in(resetn_in), .lock_in(lock_in),
    .local_button_in(local_button_in), .signal_present_in(signal_present_in),
    .above_range_in(above_range_in), .below_range_in(below_range_in),
    .hw_error_in(hw_error_in), .syntax_error_in(syntax_error_in),
    .measure_done_in(measure_done_in), .fn_in(fn_in), .converter_in(converter_in),
    .mask_wr_in(mask_wr_in), .mask_in(mask_in), .sel_wr_in(sel_wr_in), .sel_in(sel_in),
    .poll_done_in(poll_done_in), .talk_req_in(talk_req_in), .talk_ready_in(talk_ready_in),
    .poll_byte_out(poll_byte_out), .srq_out(srq_out), .status_mode_out(status_mode_out),
    .talk_data_out(talk_data_out), .talk_valid_out(talk_valid_out),
    .talk_last_out(talk_last_out), .discard_out(discard_out)
  );
  bus_controller_model ctl (
    .mclk_in(mclk_in), .poll_byte_in(poll_byte_out), .talk_data_in(talk_data_out),
    .talk_valid_in(talk_valid_out), .talk_last_in(talk_last_out), .slow_in(slow),
    .poll_done_out(poll_done_in), .talk_ready_out(talk_ready_in)
  );
  // ----------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------
  always #25 mclk_in = ~mclk_in;
  always @(posedge mclk_in) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      fail_count++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (fail_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
  endtask : tick
  function automatic logic [7:0] hex_char(input logic [3:0] n);
    return (n < 4'ha) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
  endfunction : hex_char
  // One-cycle presses; the synchroniser still sees the edge
  task automatic pulse(input int i);
    case (i)
      0: measure_done_in <= 1'b1;
      1: signal_present_in <= 1'b1;
      2: syntax_error_in <= 1'b1;
      3: hw_error_in <= 1'b1;
      default: local_button_in <= 1'b1;
    endcase
    tick(1);
    {measure_done_in, signal_present_in, syntax_error_in, hw_error_in, local_button_in} <= 5'h00;
  endtask : pulse
  task automatic set_mask(input logic [5:0] m);
    @(posedge mclk_in);
    mask_wr_in <= 1'b1;
    mask_in <= m;
    @(posedge mclk_in);
    mask_wr_in <= 1'b0;
    tick(3);
  endtask : set_mask
  task automatic request(input logic [2:0] s);
    @(posedge mclk_in);
    sel_wr_in <= 1'b1;
    sel_in <= s;
    @(posedge mclk_in);
    sel_wr_in <= 1'b0;
    talk_req_in <= 1'b1;
    @(posedge mclk_in);
    talk_req_in <= 1'b0;
  endtask : request
  task automatic read_status(input logic [2:0] s, input logic [15:0] v, input int nhex);
    int k;
    k = 0;
    ctl.clear_rx();
    request(s);
    while (!ctl.rx_end && k < 40) begin
      tick(1);
      k++;
    end
    check("reply length", 16'(ctl.rx_n), 16'(nhex + 1));
    check("reply lead", {8'h00, ctl.rx[0]}, 16'h0053);
    for (int i = 1; i <= nhex; i++) begin
      check("reply digit", {8'h00, ctl.rx[i]}, {8'h00, hex_char(v[4*(nhex-i) +: 4])});
    end
  endtask : read_status
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_power_and_mask();
    check("power byte", {8'h00, poll_byte_out}, 16'h00c0);
    check("bus request", {15'h0, srq_out}, 16'h0001);
    ctl.serial_poll(pb, rqs);
    check("polled byte", {8'h00, pb}, 16'h00c0);
    check("polled request", {15'h0, rqs}, 16'h0001);
    tick(2);
    check("byte after poll", {8'h00, poll_byte_out}, 16'h0000);
    pulse(0);
    tick(4);
    check("ready masked", {8'h00, poll_byte_out}, 16'h0000);
    set_mask(6'h3f);
    check("ready unmasked", {8'h00, poll_byte_out}, 16'h0041);
    ctl.serial_poll(pb, rqs);
  endtask : t_power_and_mask
  task automatic t_causes();
    for (int i = 0; i < 5; i++) begin
      pulse(i);
      tick(8);
      check("cause byte", {8'h00, poll_byte_out}, 16'h0040 | (16'h0001 << i));
      ctl.serial_poll(pb, rqs);
      tick(2);
      check("cause cleared", {8'h00, poll_byte_out}, 16'h0000);
    end
    set_mask(6'h12);
    pulse(3);
    pulse(4);
    tick(8);
    check("partial mask", {8'h00, poll_byte_out}, 16'h0050);
    ctl.serial_poll(pb, rqs);
    set_mask(6'h3f);
  endtask : t_causes
  task automatic t_lock();
    lock_in <= 1'b1;
    tick(8);
    check("lock set", {8'h00, poll_byte_out}, 16'h0060);
    lock_in <= 1'b0;
    tick(8);
    check("lock lost", {8'h00, poll_byte_out}, 16'h0000);
  endtask : t_lock
  task automatic t_registers();
    read_status(3'h1, 16'h009f, 2);
    slow <= 1'b1;
    read_status(3'h1, 16'h0000, 2);
    signal_present_in <= 1'b1;
    above_range_in <= 1'b1;
    tick(8);
    read_status(3'h2, 16'h000e, 2);
    above_range_in <= 1'b0;
    below_range_in <= 1'b1;
    tick(8);
    read_status(3'h2, 16'h0005, 2);
    fn_in <= srq_status_pkg::instr_fn_t'(8'hd5);
    read_status(3'h3, 16'h00d5, 2);
    slow <= 1'b0;
    fn_in <= srq_status_pkg::instr_fn_t'(8'h2a);
    read_status(3'h3, 16'h002a, 2);
    converter_in <= 16'hbe07;
    read_status(3'h4, 16'hbe07, 4);
    request(3'h5);
    tick(5);
    check("bad select", {14'h0, talk_valid_out, status_mode_out}, 16'h0000);
  endtask : t_registers
  initial begin
    tick(12);
    resetn_in <= 1'b1;
    tick(2);
    t_power_and_mask();
    t_causes();
    t_lock();
    t_registers();
    print_verdict();
  end
endmodule : status_and_service_request_regs_test
`default_nettype wire
